/* design/gpio56_top.sv */
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/100ps
//==========================================================================
// General-purpose ports 5 and 6 with port 5 pin multiplexing
//==========================================================================
// Functional notes
// [RULE_01] Port 5 latch drives general outputs, resets 0
// [RULE_02] Port 5 output pins read back latch
// [RULE_03] Port 5 input pins read sampled level
// [RULE_04] Port 5 bits 7..3 reserved, all ones
// [RULE_05] Pin 2 I2C clock when enabled, no select
// [RULE_06] Pin 2 serial clock in/out when selected
// [RULE_07] Software clears serial clock bits before I2C
// [RULE_08] Pin 1 serial receive when selected and enabled
// [RULE_09] Pin 0 serial transmit when selected and enabled
// [RULE_10] Port 6 direction write-only, resets 0
// [RULE_11] Port 6 latch read/write, drives outputs
// [RULE_12] Port 6 output pins read back latch
// [RULE_13] Port 6 input pins read sampled level
// [RULE_14] Port 6 four selectable input levels, output
// [RULE_15] Port 5 direction write-only, resets 0
// [RULE_16] Input level field 00 standard to 11
// [RULE_17] Direction reads give ones; writes take effect
// [RULE_18] Pin reads pass a two-stage synchroniser
module gpio56_top
    import gpio56_pkg::*;
(
    input wire logic clk_sys,               // System clock, 100 MHz
    input wire logic nrst,                  // Async reset, active low
    input wire bus_req_type bus,            // Register request
    output logic [DATA_W-1:0] rdata,        // Read data, cycle after read
    input wire logic [P5_W-1:0] p5_in,      // Port 5 pin levels
    output p5_drive_type p5_drive,          // Port 5 pin drive
    input wire logic [P6_W-1:0] p6_in,      // Port 6 pin levels
    output logic [P6_W-1:0] p6_out,         // Port 6 pin output level
    output logic [P6_W-1:0] p6_oe,          // Port 6 pin output enable
    input wire periph_ctl_type periph_ctl,  // Peripheral controls
    output periph_in_type periph_in,        // Pin levels to peripherals
    output level_type input_level           // Port 6 input buffer level
);

    //======================================================================
    // State
    //======================================================================

    // All registered state of the block except the pin synchroniser stages
    typedef struct packed {
        logic [P5_W-1:0] p5_dir;            // port5_direction
        logic [P5_W-1:0] p5_out;            // port5_out_latch
        logic [P6_W-1:0] p6_dir;            // port6_direction
        logic [P6_W-1:0] p6_out;            // port6_out_latch
        level_type level;                   // Input level select
        logic pin_sel;                      // serial_pin_select
        logic [DATA_W-1:0] rdata;           // Read data register
        p5_drive_type p5_drive;             // Registered port 5 drive
        logic [P6_W-1:0] p6_pin_out;        // Registered port 6 level
        logic [P6_W-1:0] p6_pin_oe;         // Registered port 6 enable
        periph_in_type periph;              // Registered peripheral inputs
    } top_state_type;

    top_state_type state;                   // Registered state
    top_state_type next_state;              // Next state

    logic [P5_W-1:0] p5_level;              // Synchronised port 5 pins
    logic [P6_W-1:0] p6_level;              // Synchronised port 6 pins
    logic [P5_W-1:0] p5_read;               // Port 5 read value
    logic [P6_W-1:0] p6_read;               // Port 6 read value
    p5_drive_type next_p5_drive;            // Port 5 drive from the mux
    periph_in_type next_periph;             // Peripheral inputs from mux

    //======================================================================
    // Pin synchronisers
    //======================================================================

    // Port 5 pins into the clock domain
    pin_sync #(
        .WIDTH(P5_W)
    ) u_p5_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pin_in(p5_in),
        .pin_sync_out(p5_level)             // [RULE_18]
    );

    // Port 6 pins into the clock domain
    pin_sync #(
        .WIDTH(P6_W)
    ) u_p6_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pin_in(p6_in),
        .pin_sync_out(p6_level)             // [RULE_18]
    );

    //======================================================================
    // Port 5 function selection
    //======================================================================

    // Decide what drives each port 5 pin
    pin5_mux u_p5_mux (
        .serial_pin_select(state.pin_sel),
        .dir(state.p5_dir),
        .latch(state.p5_out),
        .ctl(periph_ctl),
        .pin_level(p5_level),
        .drive(next_p5_drive),
        .periph(next_periph)
    );

    //======================================================================
    // Port read values
    //======================================================================

    // Per pin: latch when output, sampled pin when input
    genvar gi;
    generate
        for (gi = 0; gi < P6_W; gi++) begin : g_p6_read
            assign p6_read[gi] = state.p6_dir[gi]
                ? state.p6_out[gi]          // [RULE_12]
                : p6_level[gi];             // [RULE_13]
        end
        for (gi = 0; gi < P5_W; gi++) begin : g_p5_read
            assign p5_read[gi] = state.p5_dir[gi]
                ? state.p5_out[gi]          // [RULE_02]
                : p5_level[gi];             // [RULE_03]
        end
    endgenerate

    //======================================================================
    // Next state
    //======================================================================

    // Register writes, read data and pin drive
    always_comb begin
        next_state = state;
        // Writes land on the edge that ends the write cycle
        if (bus.wr) begin
            unique case (bus.addr)
                OFF_P5_DIR: begin
                    next_state.p5_dir = bus.wdata[P5_W-1:0]; // [RULE_15]
                end
                OFF_P5_OUT: begin
                    // Reserved upper bits are not stored
                    next_state.p5_out = bus.wdata[P5_W-1:0]; // [RULE_01]
                end
                OFF_P6_DIR: begin
                    next_state.p6_dir = bus.wdata;           // [RULE_10]
                end
                OFF_P6_OUT: begin
                    next_state.p6_out = bus.wdata;           // [RULE_11]
                end
                OFF_LEVEL: begin
                    next_state.level =
                        level_type'(bus.wdata[LEVEL_MSB:LEVEL_LSB]); // [RULE_16]
                end
                OFF_PINSEL: begin
                    next_state.pin_sel = bus.wdata[PINSEL_BIT];
                end
                default: begin
                    // Unmapped write is ignored
                end
            endcase
        end
        // Read data stands only in the cycle after the read strobe
        next_state.rdata = NO_READ;
        if (bus.rd) begin
            unique case (bus.addr)
                OFF_P5_DIR: begin
                    next_state.rdata = WO_READ;              // [RULE_17]
                end
                OFF_P5_OUT: begin
                    next_state.rdata = {P5_RSVD, p5_read};   // [RULE_04]
                end
                OFF_P6_DIR: begin
                    next_state.rdata = WO_READ;              // [RULE_17]
                end
                OFF_P6_OUT: begin
                    next_state.rdata = p6_read;
                end
                OFF_LEVEL: begin
                    next_state.rdata = {6'h00, state.level};
                end
                OFF_PINSEL: begin
                    next_state.rdata = {7'h00, state.pin_sel};
                end
                default: begin
                    next_state.rdata = NO_READ;              // Unmapped
                end
            endcase
        end
        // Pin drive follows the registers one cycle later
        next_state.p5_drive = next_p5_drive;                 // [RULE_01]
        next_state.periph = next_periph;
        next_state.p6_pin_out = state.p6_out;                // [RULE_11]
        next_state.p6_pin_oe = state.p6_dir;                 // [RULE_10]
    end

    //======================================================================
    // State register
    //======================================================================

    // Reset to documented values, otherwise take next state
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state.p5_dir <= RST_P5_DIR;                      // [RULE_15]
            state.p5_out <= RST_P5_OUT;                      // [RULE_01]
            state.p6_dir <= RST_P6_DIR;                      // [RULE_10]
            state.p6_out <= RST_P6_OUT;                      // [RULE_11]
            state.level <= RST_LEVEL;                        // [RULE_16]
            state.pin_sel <= RST_PINSEL;
            state.rdata <= NO_READ;
            state.p5_drive <= '0;
            state.p6_pin_out <= '0;
            state.p6_pin_oe <= '0;
            state.periph <= '1;                              // Idle high
        end else begin
            state <= next_state;
        end
    end

    //======================================================================
    // Outputs, all straight from flip-flops
    //======================================================================

    assign rdata = state.rdata;
    assign p5_drive = state.p5_drive;
    assign p6_out = state.p6_pin_out;
    assign p6_oe = state.p6_pin_oe;
    assign periph_in = state.periph;
    assign input_level = state.level;                        // [RULE_14]

endmodule : gpio56_top

/* design/gpio56_pkg.sv */
//==========================================================================
// Shared constants and carriers of the port 5 / port 6 block
//==========================================================================
package gpio56_pkg;

    // Widths
    localparam int ADDR_W = 8;              // Register address width
    localparam int DATA_W = 8;              // Register data width
    localparam int P5_W = 3;                // Pins of the 3-bit port
    localparam int P6_W = 8;                // Pins of the 8-bit port
    localparam int RSVD_W = DATA_W - P5_W;  // Reserved upper bits, port 5

    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_P5_DIR = 8'h00;   // port5_direction
    localparam logic [ADDR_W-1:0] OFF_P5_OUT = 8'h01;   // port5_out_latch
    localparam logic [ADDR_W-1:0] OFF_P6_DIR = 8'h02;   // port6_direction
    localparam logic [ADDR_W-1:0] OFF_P6_OUT = 8'h03;   // port6_out_latch
    localparam logic [ADDR_W-1:0] OFF_LEVEL = 8'h04;    // Input level select
    localparam logic [ADDR_W-1:0] OFF_PINSEL = 8'h05;   // serial_pin_select_reg

    // Field positions
    localparam int LEVEL_LSB = 0;           // input_level_sel_lo position
    localparam int LEVEL_MSB = 1;           // input_level_sel_hi position
    localparam int PINSEL_BIT = 0;          // serial_pin_select position
    localparam int PIN_CLK = 2;             // Clock / I2C clock pin
    localparam int PIN_RX = 1;              // Alternate receive pin
    localparam int PIN_TX = 0;              // Alternate transmit pin

    // Values after reset and fixed read values
    localparam logic [P5_W-1:0] RST_P5_DIR = 3'h0;
    localparam logic [P5_W-1:0] RST_P5_OUT = 3'h0;
    localparam logic [RSVD_W-1:0] P5_RSVD = 5'h1F;      // Reserved, all ones
    localparam logic [P6_W-1:0] RST_P6_DIR = 8'h00;
    localparam logic [P6_W-1:0] RST_P6_OUT = 8'h00;
    localparam logic RST_PINSEL = 1'h0;
    localparam logic [DATA_W-1:0] WO_READ = 8'hFF;      // Write-only readback
    localparam logic [DATA_W-1:0] NO_READ = 8'h00;      // Unmapped / idle

    // Input level of the 8-bit port
    typedef enum logic [1:0] {
        LEVEL_STD = 2'h0,                   // Standard input level
        LEVEL_1 = 2'h1,                     // Input level 1
        LEVEL_2 = 2'h2,                     // Input level 2
        LEVEL_3 = 2'h3                      // Input level 3
    } level_type;
    localparam level_type RST_LEVEL = LEVEL_STD;

    // Register port request
    typedef struct packed {
        logic wr;                           // Write strobe
        logic rd;                           // Read strobe
        logic [ADDR_W-1:0] addr;            // Register offset
        logic [DATA_W-1:0] wdata;           // Write data
    } bus_req_type;

    // Controls coming from the serial and I2C peripherals
    typedef struct packed {
        logic i2c_on;                       // I2C channel 0 enabled
        logic sci_clk_in_sel;               // Serial external clock in
        logic sci_clk_out_sel;              // Serial clock out
        logic sync_mode;                    // Serial synchronous mode
        logic rx_on;                        // Serial receive enable
        logic tx_on;                        // Serial transmit enable
        logic scl_pull_low;                 // I2C wants clock line low
        logic sci_clk_out;                  // Serial clock to drive
        logic sci_tx;                       // Serial transmit data
    } periph_ctl_type;

    // Pin levels handed to the peripherals
    typedef struct packed {
        logic i2c0_clock_line;              // Clock line level to I2C
        logic alt_serial_clock;             // External clock to serial
        logic alt_serial_rx;                // Receive data to serial
    } periph_in_type;

    // Drive of the 3-bit port pins
    typedef struct packed {
        logic [P5_W-1:0] out;               // Pin output level
        logic [P5_W-1:0] oe;                // Pin output enable
    } p5_drive_type;

endpackage : gpio56_pkg

/* design/pin_sync.sv */
`timescale 1ns/100ps
//==========================================================================
// Two-stage synchroniser for pin levels
//==========================================================================
module pin_sync
    import gpio56_pkg::*;
#(
    parameter int WIDTH = 8                 // Number of pins
) (
    input wire logic clk_sys,               // System clock
    input wire logic nrst,                  // Async reset, active low
    input wire logic [WIDTH-1:0] pin_in,    // Raw pin levels
    output logic [WIDTH-1:0] pin_sync_out   // Synchronised levels
);

    // Both stages as one state
    typedef struct packed {
        logic [WIDTH-1:0] meta;             // First stage, read by second
        logic [WIDTH-1:0] stable;           // Second stage
    } sync_state_type;

    sync_state_type state;                  // Registered state
    sync_state_type next_state;             // Next state

    // Shift pin levels through two stages
    always_comb begin
        next_state.meta = pin_in;
        next_state.stable = state.meta;
    end

    // Register the state
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pin_sync_out = state.stable;

endmodule : pin_sync

/* design/pin5_mux.sv */
`timescale 1ns/100ps
//==========================================================================
// Function selection of the 3-bit port pins
//==========================================================================
module pin5_mux
    import gpio56_pkg::*;
(
    input wire logic serial_pin_select,     // Serial pins moved to port 5
    input wire logic [P5_W-1:0] dir,        // port5_direction
    input wire logic [P5_W-1:0] latch,      // port5_out_latch
    input wire periph_ctl_type ctl,         // Peripheral controls
    input wire logic [P5_W-1:0] pin_level,  // Synchronised pin levels
    output p5_drive_type drive,             // Next pin drive
    output periph_in_type periph            // Next peripheral inputs
);

    // Pick the function of each pin
    always_comb begin
        drive.out = latch;                  // General output by default
        drive.oe = dir;
        periph.i2c0_clock_line = 1'b1;      // Idle high when not routed
        periph.alt_serial_clock = 1'b1;
        periph.alt_serial_rx = 1'b1;
        // Clock pin: serial clock has priority over I2C when selected
        if (serial_pin_select && ctl.sci_clk_in_sel) begin
            drive.oe[PIN_CLK] = 1'b0;       // External clock input [RULE_06]
            periph.alt_serial_clock = pin_level[PIN_CLK];
        end else if (serial_pin_select
                     && (ctl.sci_clk_out_sel || ctl.sync_mode)) begin
            drive.oe[PIN_CLK] = 1'b1;       // Clock output [RULE_06]
            drive.out[PIN_CLK] = ctl.sci_clk_out;
        end else if (ctl.i2c_on) begin
            // Open drain: only ever pulls low [RULE_05] [RULE_06] [RULE_07]
            drive.oe[PIN_CLK] = ctl.scl_pull_low;
            drive.out[PIN_CLK] = 1'b0;
            periph.i2c0_clock_line = pin_level[PIN_CLK];
        end
        // Receive pin
        if (serial_pin_select && ctl.rx_on) begin
            drive.oe[PIN_RX] = 1'b0;        // Receive data input [RULE_08]
            periph.alt_serial_rx = pin_level[PIN_RX];
        end
        // Transmit pin
        if (serial_pin_select && ctl.tx_on) begin
            drive.oe[PIN_TX] = 1'b1;        // Transmit data output [RULE_09]
            drive.out[PIN_TX] = ctl.sci_tx;
        end
    end

endmodule : pin5_mux

/* verif/gpio56_board.sv */
`timescale 1ns/100ps
//==========================================================================
// Board side: each pin level from the block drive and the board
//==========================================================================
module gpio56_board
    import gpio56_pkg::*;
(
    input wire p5_drive_type p5_drive,      // Port 5 drive from the block
    input wire logic [P6_W-1:0] p6_out,     // Port 6 level from the block
    input wire logic [P6_W-1:0] p6_oe,      // Port 6 enable from the block
    input wire logic [P5_W-1:0] p5_board,   // Board level, port 5
    input wire logic [P6_W-1:0] p6_board,   // Board level, port 6
    input wire logic [P5_W-1:0] p5_short,   // Board overpowers port 5 pins
    input wire logic [P6_W-1:0] p6_short,   // Board overpowers port 6 pins
    output logic [P5_W-1:0] p5_in,          // Port 5 pin levels
    output logic [P6_W-1:0] p6_in           // Port 6 pin levels
);
    // Driven pins follow the block unless the board overpowers them;
    // released pins sit at the board level set by the test
    always_comb begin
        p5_in = (p5_drive.oe & ~p5_short & p5_drive.out)
            | ((~p5_drive.oe | p5_short) & p5_board);
        p6_in = (p6_oe & ~p6_short & p6_out)
            | ((~p6_oe | p6_short) & p6_board);
    end
endmodule : gpio56_board

/* verif/gpio56_sva.sv */
`timescale 1ns/100ps
//==========================================================================
// Port 5 / port 6 checker
//==========================================================================
module gpio56_sva
    import gpio56_pkg::*;
(
    input wire logic clk_sys,               // System clock
    input wire logic nrst,                  // Async reset, active low
    input wire bus_req_type bus,            // Register request
    input wire logic [DATA_W-1:0] rdata,    // Read data
    input wire logic [P5_W-1:0] p5_in,      // Port 5 pins
    input wire p5_drive_type p5_drive,      // Port 5 drive
    input wire logic [P6_W-1:0] p6_in,      // Port 6 pins
    input wire logic [P6_W-1:0] p6_out,     // Port 6 level
    input wire logic [P6_W-1:0] p6_oe,      // Port 6 enable
    input wire periph_ctl_type periph_ctl,  // Peripheral controls
    input wire periph_in_type periph_in,    // Levels to peripherals
    input wire level_type input_level       // Input level select
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic sel_q; // Pin select as last written
    logic wr_lvl; // Write to the level register
    assign wr_lvl = bus.wr && bus.addr == OFF_LEVEL;
    // Shadow of the serial pin select register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sel_q <= RST_PINSEL;
        end else if (bus.wr && bus.addr == OFF_PINSEL) begin
            sel_q <= bus.wdata[PINSEL_BIT];
        end
    end
    //======================================================================
    // Assertions
    //======================================================================
    wo_read_ones_a: assert property ((bus.rd && (bus.addr == OFF_P5_DIR
        || bus.addr == OFF_P6_DIR)) |=> rdata == WO_READ)
        else $error("direction read not all ones");
    rsvd_bits_a: assert property ((bus.rd && bus.addr == OFF_P5_OUT)
        |=> rdata[DATA_W-1:P5_W] == P5_RSVD) else $error("reserved bits");
    p6_latch_out_a: assert property ((bus.wr && bus.addr == OFF_P6_OUT)
        |-> ##2 p6_out == $past(bus.wdata, 2)) else $error("p6 level");
    p6_dir_oe_a: assert property ((bus.wr && bus.addr == OFF_P6_DIR)
        |-> ##2 p6_oe == $past(bus.wdata, 2)) else $error("p6 enable");
    level_cause_a: assert property ($changed(input_level)
        |-> $past(wr_lvl) || $past(wr_lvl, 2)) else $error("level moved");
    rx_release_a: assert property ((sel_q && periph_ctl.rx_on)
        |=> !p5_drive.oe[PIN_RX]) else $error("receive pin driven");
    tx_drive_a: assert property ((sel_q && periph_ctl.tx_on) |=>
        p5_drive.oe[PIN_TX] && p5_drive.out[PIN_TX] == $past(periph_ctl.sci_tx))
        else $error("transmit pin wrong");
    clk_out_a: assert property ((sel_q && !periph_ctl.sci_clk_in_sel
        && (periph_ctl.sci_clk_out_sel || periph_ctl.sync_mode)) |=>
        p5_drive.oe[PIN_CLK] && p5_drive.out[PIN_CLK] ==
        $past(periph_ctl.sci_clk_out)) else $error("clock out wrong");
    scl_drive_a: assert property ((!sel_q && periph_ctl.i2c_on) |=>
        p5_drive.oe[PIN_CLK] == $past(periph_ctl.scl_pull_low)
        && !p5_drive.out[PIN_CLK]) else $error("i2c clock drive wrong");
    p6_read_c: cover property (bus.rd && bus.addr == OFF_P6_OUT);
    tx_route_c: cover property (sel_q && periph_ctl.tx_on);
    scl_pull_c: cover property (periph_ctl.i2c_on && p5_drive.oe[PIN_CLK]);
endmodule : gpio56_sva

bind gpio56_top gpio56_sva i_sva (.clk_sys(clk_sys), .nrst(nrst), .bus(bus),
    .rdata(rdata), .p5_in(p5_in), .p5_drive(p5_drive), .p6_in(p6_in),
    .p6_out(p6_out), .p6_oe(p6_oe), .periph_ctl(periph_ctl),
    .periph_in(periph_in), .input_level(input_level));

/* verif/test_gpio56_top.sv */
`timescale 1ns/100ps
//==========================================================================
// Register-level test of ports 5 and 6
//==========================================================================
module test_gpio56_top
    import gpio56_pkg::*;
;
    logic clk_sys, nrst; // Clock and reset
    bus_req_type bus; // Register request
    logic [DATA_W-1:0] rdata; // Read data
    logic [P5_W-1:0] p5_in, p5_board, p5_short; // Port 5 pins and board
    logic [P6_W-1:0] p6_in, p6_board, p6_short, p6_out, p6_oe; // Port 6
    p5_drive_type p5_drive; // Port 5 drive
    periph_ctl_type periph_ctl; // Peripheral controls
    periph_in_type periph_in; // Levels to peripherals
    level_type input_level; // Input level select
    int mismatches, checks_done; // Counters
    gpio56_top i_dut (.clk_sys(clk_sys), .nrst(nrst), .bus(bus),
        .rdata(rdata), .p5_in(p5_in), .p5_drive(p5_drive), .p6_in(p6_in),
        .p6_out(p6_out), .p6_oe(p6_oe), .periph_ctl(periph_ctl),
        .periph_in(periph_in), .input_level(input_level));
    gpio56_board i_board (.p5_drive(p5_drive), .p6_out(p6_out),
        .p6_oe(p6_oe), .p5_board(p5_board), .p6_board(p6_board),
        .p5_short(p5_short), .p6_short(p6_short), .p5_in(p5_in),
        .p6_in(p6_in));
    // Clock at 100 MHz
    always #5 clk_sys = ~clk_sys;
    //======================================================================
    // Tasks
    //======================================================================
    task automatic chk(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        bus <= '0;
    endtask : wr
    task automatic rdchk(input string what, input logic [7:0] a,
        input logic [7:0] exp);
        @(posedge clk_sys);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        bus <= '0;
        @(negedge clk_sys);
        chk(what, rdata, exp);
    endtask : rdchk
    task automatic settle;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle
    task automatic chk5(input logic [2:0] oe, input logic [2:0] out);
        settle();
        chk("p5 oe", {5'h00, p5_drive.oe}, {5'h00, oe});
        chk("p5 out", {5'h00, p5_drive.out & p5_drive.oe}, {5'h00, out});
    endtask : chk5
    task automatic summarize;
        $display("Checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        summarize();
    end
    //======================================================================
    // Main sequence
    //======================================================================
    initial begin
        clk_sys = 1'b0;
        nrst = 1'b0;
        bus = '0;
        periph_ctl = '0;
        p5_board = 3'h1;
        p6_board = 8'h3C;
        p5_short = 3'h0;
        p6_short = 8'h00;
        mismatches = 0;
        checks_done = 0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        rdchk("p5 dir", OFF_P5_DIR, 8'hFF);
        rdchk("p6 dir", OFF_P6_DIR, 8'hFF);
        rdchk("p5 port", OFF_P5_OUT, 8'hF9);
        rdchk("p6 port", OFF_P6_OUT, 8'h3C);
        rdchk("level", OFF_LEVEL, 8'h00);
        rdchk("unmapped", 8'h40, 8'h00);
        chk("p6 drive", p6_oe | p6_out, 8'h00);
        chk("p5 drive", {2'h0, p5_drive}, 8'h00);
        $display("Test reset values done");
        // Board overpowers port 6 so latch and pin differ
        wr(OFF_P6_OUT, 8'hA5);
        wr(OFF_P6_DIR, 8'hF0);
        p6_short <= 8'hFF;
        settle();
        chk("p6_out", p6_out, 8'hA5);
        chk("p6_oe", p6_oe, 8'hF0);
        rdchk("p6 mixed", OFF_P6_OUT, 8'hAC);
        wr(OFF_P6_DIR, 8'h0F);
        rdchk("p6 swapped", OFF_P6_OUT, 8'h35);
        p6_short <= 8'h00;
        $display("Test port 6 done");
        // Upper bits written as ones; they are not stored and read back as ones
        wr(OFF_P5_OUT, 8'hFE);
        wr(OFF_P5_DIR, 8'hFF);
        p5_short <= 3'h7;
        chk5(3'h7, 3'h6);
        rdchk("p5 out", OFF_P5_OUT, 8'hFE);
        wr(OFF_P5_DIR, 8'hFC);
        rdchk("p5 mixed", OFF_P5_OUT, 8'hFD);
        p5_short <= 3'h0;
        $display("Test port 5 done");
        for (int i = 0; i < 4; i++) begin
            wr(OFF_LEVEL, 8'(i));
            settle();
            chk("input_level", {6'h00, input_level}, 8'(i));
        end
        $display("Test input level done");
        // Alternate functions with the serial pins selected
        wr(OFF_P5_DIR, 8'hFF);
        wr(OFF_PINSEL, 8'h01);
        periph_ctl <= '{tx_on: 1'b1, rx_on: 1'b1, sci_tx: 1'b1,
            sci_clk_in_sel: 1'b1, default: 1'b0};
        chk5(3'h1, 3'h1);
        chk("periph_in", {5'h00, periph_in}, 8'h04);
        p5_board <= 3'h7;
        settle();
        chk("periph_in", {5'h00, periph_in}, 8'h07);
        periph_ctl <= '{sync_mode: 1'b1, sci_clk_out: 1'b1, default: 1'b0};
        chk5(3'h7, 3'h6);
        periph_ctl <= '{sci_clk_out_sel: 1'b1, default: 1'b0};
        chk5(3'h7, 3'h2);
        // Serial clock bits cleared before the I2C clock takes the pin
        periph_ctl <= '{i2c_on: 1'b1, default: 1'b0};
        p5_board <= 3'h3;
        chk5(3'h3, 3'h2);
        chk("periph_in", {5'h00, periph_in}, 8'h03);
        wr(OFF_PINSEL, 8'h00);
        periph_ctl <= '{i2c_on: 1'b1, scl_pull_low: 1'b1, default: 1'b0};
        chk5(3'h7, 3'h2);
        periph_ctl <= '{tx_on: 1'b1, rx_on: 1'b1, default: 1'b0};
        chk5(3'h7, 3'h6);
        $display("Test pin functions done");
        summarize();
    end
endmodule : test_gpio56_top
